// [npp_host_model.sv]
// host flash controller model: drives link strobes, collects bytes
// assumes the target samples link fields on the rising link clock
`timescale 1ns/10ps
`default_nettype none
module npp_host_model
(
    input wire logic link_clk_i,
    input wire npp_pkg::npp_link_out_type dev_i,
    output var npp_pkg::npp_link_in_type link_o
);
    import npp_pkg::*;
    logic [7:0] sink;
    initial link_o = '0;
    // one strobe cycle; released bus shows inverse data
    task automatic put(input int k, input logic [7:0] b, output logic [7:0] q);
        @(negedge link_clk_i);
        link_o = '{k == 0, k == 1, k == 2, k == 3, b};
        @(negedge link_clk_i);
        q = dev_i.dq;
        link_o = '{1'b0, 1'b0, 1'b0, 1'b0, ~b};
    endtask
    // enhanced status and enhanced column change are never issued
    task automatic cmd(input logic [7:0] b);
        put(0, b, sink);
    endtask
    task automatic adr(input logic [7:0] b);
        put(1, b, sink);
    endtask
    task automatic wr(input logic [7:0] b);
        put(2, b, sink);
    endtask
    task automatic rd(output logic [7:0] q);
        put(3, 8'h00, q);
    endtask
    // open page, poll status, then restore data output
    task automatic page_open(output logic [7:0] first, output logic [7:0] last);
        cmd(CMD_READ_PP);
        adr(PP_ADDR_VAL);
        cmd(CMD_STATUS);
        rd(first);
        last = first;
        for (int n = 0; n < 40 && last !== 8'h60; n++)
        begin
            cmd(CMD_STATUS);
            rd(last);
        end
        cmd(CMD_READ_MODE);
    endtask
endmodule // npp_host_model
`default_nettype wire

// [npp_pkg.sv]
// constants, types and parameter-page layout for the parameter page and array mode block
// assumes a link side that presents command, address and data latches on its own clock
// Functional notes
// - feature 90h byte bit 0 selects normal or one-time block access; rest zero.
// - reset command returns the array operation mode to normal access.
// - read-parameter-page command taken only while all logical units are idle.
// - read-parameter-page mode holds until another valid command arrives.
// - opcode followed by one 00h address; target then busy for page load time.
// - asynchronous interface gives one parameter byte per read strobe toggle.
// - synchronous interface gives one byte on each rising and falling strobe edge.
// - at least seven copies of the page are held, 256 bytes each.
// - change-read-column pair moves output to the new byte location.
// - bytes 0 to 3 hold the signature O, N, F, I.
// - bytes 4 to 5 hold the revision field 1Eh, 00h.
// - bytes 6 to 7 flag supported features; bits 15 to 9 zero.
// - feature bits 2, 1, 0 flag non-sequential program, multi-unit, wide bus.
// - bytes 8 to 9 flag optional commands, value FFh, 02h.
package npp_pkg;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_READ_PP = 8'hec;
    localparam logic [7:0] CMD_READ_MODE = 8'h00;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_COL = 8'h05;
    localparam logic [7:0] CMD_COL_CFM = 8'he0;
    localparam logic [7:0] CMD_SET_FEAT = 8'hef;
    localparam logic [7:0] CMD_GET_FEAT = 8'hee;
    localparam logic [7:0] PP_ADDR_VAL = 8'h00;
    localparam logic [7:0] FEAT_ADDR_ARRAY = 8'h90;
    localparam logic ARRAY_MODE_RESET = 1'b0;
    localparam int ARRAY_MODE_BIT = 0;
    localparam logic [1:0] FEAT_LAST_IDX = 2'h3;
    localparam int PP_BYTES = 256;
    localparam int PP_COPIES = 7;
    localparam int COL_W = 11;
    localparam logic [COL_W-1:0] COL_LAST = COL_W'(PP_BYTES * PP_COPIES - 1);
    localparam logic [COL_W-1:0] COL_ONE = 11'h001;
    localparam logic [COL_W-1:0] COL_ZERO = 11'h000;
    localparam logic [7:0] SIG_B0 = 8'h4f;
    localparam logic [7:0] SIG_B1 = 8'h4e;
    localparam logic [7:0] SIG_B2 = 8'h46;
    localparam logic [7:0] SIG_B3 = 8'h49;
    localparam logic [15:0] REV_VAL = 16'h001e;
    localparam logic [15:0] OPT_CMD_VAL = 16'h02ff;
    localparam logic [15:0] FEATURES_DEF = 16'h01d8;
    localparam logic [7:0] PP_COUNT_VAL = 8'h03;
    localparam logic [7:0] IDX_SIG0 = 8'h00;
    localparam logic [7:0] IDX_SIG1 = 8'h01;
    localparam logic [7:0] IDX_SIG2 = 8'h02;
    localparam logic [7:0] IDX_SIG3 = 8'h03;
    localparam logic [7:0] IDX_REV_LO = 8'h04;
    localparam logic [7:0] IDX_REV_HI = 8'h05;
    localparam logic [7:0] IDX_FEAT_LO = 8'h06;
    localparam logic [7:0] IDX_FEAT_HI = 8'h07;
    localparam logic [7:0] IDX_OPT_LO = 8'h08;
    localparam logic [7:0] IDX_OPT_HI = 8'h09;
    localparam logic [7:0] IDX_PP_COUNT = 8'h0e;
    localparam int STATUS_RDY_BIT = 6;
    localparam int STATUS_ARDY_BIT = 5;
    localparam int PAGE_LOAD_TIME_NS = 50000;
    localparam int REF_CLK_PERIOD_NS = 40;
    localparam int PAGE_LOAD_CYCLES_CALC = PAGE_LOAD_TIME_NS / REF_CLK_PERIOD_NS;
    localparam int PAGE_LOAD_CYCLES = (PAGE_LOAD_CYCLES_CALC < 1) ? 1 : PAGE_LOAD_CYCLES_CALC;

    typedef struct packed {
        logic cmd_we;
        logic addr_we;
        logic data_we;
        logic rd_strobe;
        logic [7:0] din;
    } npp_link_in_type;

    typedef struct packed {
        logic [7:0] dq;
        logic dq_oe;
        logic dqs;
    } npp_link_out_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PP_ADDR = 4'h1,
        ST_PP_BUSY = 4'h3,
        ST_PP_OUT = 4'h2,
        ST_COL_A1 = 4'h6,
        ST_COL_A2 = 4'h7,
        ST_COL_CFM = 4'h5,
        ST_SF_ADDR = 4'h4,
        ST_SF_DATA = 4'hc,
        ST_GF_ADDR = 4'hd,
        ST_GF_OUT = 4'hf,
        ST_STATUS = 4'he
    } npp_state_type;
endpackage

// [npp_pp_rom.sv]
// parameter page store: all copies, registered read data
// assumes the address is the next column, so data lines up with the current column
`timescale 1ns/10ps
`default_nettype none
module npp_pp_rom
#(
    parameter logic [15:0] FEATURES = npp_pkg::FEATURES_DEF
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [npp_pkg::COL_W-1:0] addr_i,
    output logic [7:0] rd_data_o
);
    import npp_pkg::*;

    // every copy decodes the same byte index, so copies repeat
    function automatic logic [7:0] page_byte(input logic [7:0] idx);
        case (idx)
            IDX_SIG0: page_byte = SIG_B0;
            IDX_SIG1: page_byte = SIG_B1;
            IDX_SIG2: page_byte = SIG_B2;
            IDX_SIG3: page_byte = SIG_B3;
            IDX_REV_LO: page_byte = REV_VAL[7:0];
            IDX_REV_HI: page_byte = REV_VAL[15:8];
            IDX_FEAT_LO: page_byte = FEATURES[7:0];
            IDX_FEAT_HI: page_byte = {7'h00, FEATURES[8]};
            IDX_OPT_LO: page_byte = OPT_CMD_VAL[7:0];
            IDX_OPT_HI: page_byte = OPT_CMD_VAL[15:8];
            IDX_PP_COUNT: page_byte = PP_COUNT_VAL;
            default: page_byte = 8'h00;
        endcase
    endfunction

    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;

    always_comb
    begin
        rd_data_d = page_byte(addr_i[7:0]);
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_data_q <= 8'h00;
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_o = rd_data_q;
endmodule // npp_pp_rom
`default_nettype wire

// [npp_top.sv]
// parameter page read and array operation mode feature of a flash target
// assumes link strobes arrive on link_clk_i; luns_idle_i and sync_mode_i are foreign levels
`timescale 1ns/10ps
`default_nettype none
module npp_top
#(
    parameter int PAGE_LOAD_CYC = npp_pkg::PAGE_LOAD_CYCLES,
    parameter logic [15:0] FEATURES = npp_pkg::FEATURES_DEF
)
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic link_clk_i,
    input wire npp_pkg::npp_link_in_type link_i,
    input wire logic sync_mode_i,
    input wire logic luns_idle_i,
    output npp_pkg::npp_link_out_type link_o,
    output logic rb_n_o,
    output logic array_mode_o
);
    import npp_pkg::*;

    localparam int TW = $clog2(PAGE_LOAD_CYC + 1);
    localparam logic [TW-1:0] TIMER_LOAD = TW'(PAGE_LOAD_CYC);
    localparam logic [TW-1:0] TIMER_ONE = TW'(1);
    localparam logic [TW-1:0] TIMER_ZERO = TW'(0);

    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c);
        next_col = (c == COL_LAST) ? COL_ZERO : c + COL_ONE;
    endfunction

    // ************************************************************
    // reference clock domain: page load timer
    // ************************************************************
    logic start_tgl_q;
    logic [2:0] start_sync_q;
    logic [2:0] start_sync_d;
    logic [TW-1:0] timer_q;
    logic [TW-1:0] timer_d;
    logic busy_q;
    logic busy_d;
    logic done_tgl_q;
    logic done_tgl_d;
    logic start_evt;

    always_comb
    begin
        start_sync_d = {start_sync_q[1:0], start_tgl_q};
        start_evt = start_sync_q[2] ^ start_sync_q[1];
        timer_d = timer_q;
        busy_d = busy_q;
        done_tgl_d = done_tgl_q;
        if (start_evt)
        begin
            timer_d = TIMER_LOAD;
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            timer_d = timer_q - TIMER_ONE;
            if (timer_q == TIMER_ONE)
            begin
                busy_d = 1'b0;
                done_tgl_d = ~done_tgl_q;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            start_sync_q <= 3'h0;
            timer_q <= TIMER_ZERO;
            busy_q <= 1'b0;
            done_tgl_q <= 1'b0;
        end
        else
        begin
            start_sync_q <= start_sync_d;
            timer_q <= timer_d;
            busy_q <= busy_d;
            done_tgl_q <= done_tgl_d;
        end
    end

    assign rb_n_o = ~busy_q;

    // ************************************************************
    // link clock domain: command decode and data output
    // ************************************************************
    npp_state_type state_q;
    npp_state_type state_d;
    logic [COL_W-1:0] col_q;
    logic [COL_W-1:0] col_d;
    logic [COL_W-1:0] cnew_q;
    logic [COL_W-1:0] cnew_d;
    logic [7:0] fa_q;
    logic [7:0] fa_d;
    logic [1:0] fidx_q;
    logic [1:0] fidx_d;
    logic mode_q;
    logic mode_d;
    logic lbusy_q;
    logic lbusy_d;
    logic ret_pp_q;
    logic ret_pp_d;
    logic start_tgl_d;
    logic [7:0] dq_q;
    logic [7:0] dq_d;
    logic oe_q;
    logic oe_d;
    logic dqs_q;
    logic dqs_d;
    logic [2:0] done_sync_q;
    logic [1:0] idle_sync_q;
    logic [1:0] smode_sync_q;
    logic done_evt;
    logic luns_idle;
    logic smode;
    logic [7:0] rom_q;
    logic [7:0] status_byte;

    npp_pp_rom #(
        .FEATURES(FEATURES)
    ) u_rom (
        .clk_i(link_clk_i),
        .resetn_i(resetn_i),
        .addr_i(col_d),
        .rd_data_o(rom_q)
    );

    always_ff @(posedge link_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            done_sync_q <= 3'h0;
            idle_sync_q <= 2'h0;
            smode_sync_q <= 2'h0;
        end
        else
        begin
            done_sync_q <= {done_sync_q[1:0], done_tgl_q};
            idle_sync_q <= {idle_sync_q[0], luns_idle_i};
            smode_sync_q <= {smode_sync_q[0], sync_mode_i};
        end
    end

    always_comb
    begin
        done_evt = done_sync_q[2] ^ done_sync_q[1];
        luns_idle = idle_sync_q[1];
        smode = smode_sync_q[1];
        status_byte = 8'h00;
        status_byte[STATUS_RDY_BIT] = ~lbusy_q;
        status_byte[STATUS_ARDY_BIT] = ~lbusy_q;
        state_d = state_q;
        col_d = col_q;
        cnew_d = cnew_q;
        fa_d = fa_q;
        fidx_d = fidx_q;
        mode_d = mode_q;
        lbusy_d = lbusy_q;
        ret_pp_d = ret_pp_q;
        start_tgl_d = start_tgl_q;
        dq_d = dq_q;
        dqs_d = dqs_q;
        if (done_evt)
        begin
            lbusy_d = 1'b0;
        end
        if (link_i.cmd_we)
        begin
            case (link_i.din)
                CMD_RESET:
                begin
                    mode_d = ARRAY_MODE_RESET;
                    state_d = ST_IDLE;
                    col_d = COL_ZERO;
                end
                CMD_READ_PP:
                begin
                    if (luns_idle)
                    begin
                        state_d = ST_PP_ADDR;
                    end
                end
                CMD_STATUS:
                begin
                    ret_pp_d = (state_q == ST_STATUS) ? ret_pp_q
                        : (state_q == ST_PP_BUSY) || (state_q == ST_PP_OUT);
                    state_d = ST_STATUS;
                end
                CMD_READ_MODE:
                begin
                    state_d = (state_q == ST_STATUS && ret_pp_q) ? ST_PP_BUSY : ST_IDLE;
                end
                CMD_COL:
                begin
                    if (state_q == ST_PP_OUT)
                    begin
                        state_d = ST_COL_A1;
                    end
                end
                CMD_COL_CFM:
                begin
                    if (state_q == ST_COL_CFM)
                    begin
                        state_d = ST_PP_OUT;
                        col_d = cnew_q;
                    end
                end
                CMD_SET_FEAT: state_d = ST_SF_ADDR;
                CMD_GET_FEAT: state_d = ST_GF_ADDR;
                default: state_d = state_q;
            endcase
        end
        else if (link_i.addr_we)
        begin
            case (state_q)
                ST_PP_ADDR:
                begin
                    if (link_i.din == PP_ADDR_VAL)
                    begin
                        state_d = ST_PP_BUSY;
                        lbusy_d = 1'b1;
                        start_tgl_d = ~start_tgl_q;
                        col_d = COL_ZERO;
                    end
                    else
                    begin
                        state_d = ST_IDLE;
                    end
                end
                ST_COL_A1:
                begin
                    cnew_d = {cnew_q[COL_W-1:8], link_i.din};
                    state_d = ST_COL_A2;
                end
                ST_COL_A2:
                begin
                    cnew_d = {link_i.din[COL_W-9:0], cnew_q[7:0]};
                    state_d = ST_COL_CFM;
                end
                ST_SF_ADDR:
                begin
                    fa_d = link_i.din;
                    fidx_d = 2'h0;
                    state_d = ST_SF_DATA;
                end
                ST_GF_ADDR:
                begin
                    fa_d = link_i.din;
                    fidx_d = 2'h0;
                    state_d = ST_GF_OUT;
                end
                default: state_d = state_q;
            endcase
        end
        else if (link_i.data_we && state_q == ST_SF_DATA)
        begin
            if (fidx_q == 2'h0 && fa_q == FEAT_ADDR_ARRAY)
            begin
                mode_d = link_i.din[ARRAY_MODE_BIT];
            end
            fidx_d = fidx_q + 2'h1;
            if (fidx_q == FEAT_LAST_IDX)
            begin
                state_d = ST_IDLE;
            end
        end
        else if (link_i.rd_strobe)
        begin
            case (state_q)
                ST_PP_OUT:
                begin
                    dq_d = rom_q;
                    col_d = next_col(col_q);
                    dqs_d = smode ? ~dqs_q : dqs_q;
                end
                ST_GF_OUT:
                begin
                    dq_d = 8'h00;
                    if (fidx_q == 2'h0 && fa_q == FEAT_ADDR_ARRAY)
                    begin
                        dq_d[ARRAY_MODE_BIT] = mode_q;
                    end
                    fidx_d = fidx_q + 2'h1;
                end
                ST_STATUS:
                begin
                    dq_d = status_byte;
                end
                default: dq_d = dq_q;
            endcase
        end
        if (state_q == ST_PP_BUSY && !lbusy_q && !link_i.cmd_we)
        begin
            state_d = ST_PP_OUT;
        end
        oe_d = (state_d == ST_PP_OUT) || (state_d == ST_GF_OUT) || (state_d == ST_STATUS);
    end

    always_ff @(posedge link_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_IDLE;
            col_q <= COL_ZERO;
            cnew_q <= COL_ZERO;
            fa_q <= 8'h00;
            fidx_q <= 2'h0;
            mode_q <= ARRAY_MODE_RESET;
            lbusy_q <= 1'b0;
            ret_pp_q <= 1'b0;
            start_tgl_q <= 1'b0;
            dq_q <= 8'h00;
            oe_q <= 1'b0;
            dqs_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            col_q <= col_d;
            cnew_q <= cnew_d;
            fa_q <= fa_d;
            fidx_q <= fidx_d;
            mode_q <= mode_d;
            lbusy_q <= lbusy_d;
            ret_pp_q <= ret_pp_d;
            start_tgl_q <= start_tgl_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            dqs_q <= dqs_d;
        end
    end

    assign link_o.dq = dq_q;
    assign link_o.dq_oe = oe_q;
    assign link_o.dqs = dqs_q;
    assign array_mode_o = mode_q;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_reset_cmd;
        link_i.cmd_we && link_i.din == CMD_RESET;
    endsequence

    sequence s_pp_strobe;
        state_q == ST_PP_OUT && link_i.rd_strobe && !link_i.cmd_we && !link_i.addr_we
            && !link_i.data_we;
    endsequence

    property p_mode_reset;
        @(posedge link_clk_i) disable iff (!resetn_i)
        s_reset_cmd |=> !mode_q && state_q == ST_IDLE;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not cleared");

    property p_feat_reserved;
        @(posedge link_clk_i) disable iff (!resetn_i)
        state_q == ST_GF_OUT && $past(link_i.rd_strobe) && $past(state_q) == ST_GF_OUT
            |-> dq_q[7:1] == 7'h00;
    endproperty
    a_feat_reserved: assert property (p_feat_reserved) else $error("feature bits set");

    property p_reject_busy;
        @(posedge link_clk_i) disable iff (!resetn_i)
        link_i.cmd_we && link_i.din == CMD_READ_PP && !luns_idle |=> state_q != ST_PP_ADDR;
    endproperty
    a_reject_busy: assert property (p_reject_busy) else $error("ECh taken while busy");

    property p_pp_hold;
        @(posedge link_clk_i) disable iff (!resetn_i)
        state_q == ST_PP_OUT && !link_i.cmd_we |=> state_q == ST_PP_OUT;
    endproperty
    a_pp_hold: assert property (p_pp_hold) else $error("left page mode");

    property p_busy_len;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        start_evt |=> busy_q[*8] ##0 !rb_n_o;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");

    property p_busy_end;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(busy_q) |-> $past(timer_q) == TIMER_ONE;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy ended early");

    property p_async_byte;
        @(posedge link_clk_i) disable iff (!resetn_i)
        s_pp_strobe |=> col_q == next_col($past(col_q)) && dq_q == $past(rom_q);
    endproperty
    a_async_byte: assert property (p_async_byte) else $error("byte not advanced");

    property p_sync_dqs;
        @(posedge link_clk_i) disable iff (!resetn_i)
        s_pp_strobe ##0 smode |=> dqs_q != $past(dqs_q);
    endproperty
    a_sync_dqs: assert property (p_sync_dqs) else $error("strobe not toggled");

    property p_wrap;
        @(posedge link_clk_i) disable iff (!resetn_i)
        s_pp_strobe ##0 col_q == COL_LAST |=> col_q == COL_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) else $error("copy wrap wrong");

    property p_signature;
        @(posedge link_clk_i) disable iff (!resetn_i)
        s_pp_strobe ##0 col_q[7:0] == IDX_SIG0 |=> dq_q == SIG_B0;
    endproperty
    a_signature: assert property (p_signature) else $error("bad signature");

    property p_col_change;
        @(posedge link_clk_i) disable iff (!resetn_i)
        state_q == ST_COL_CFM && link_i.cmd_we && link_i.din == CMD_COL_CFM
            |=> col_q == $past(cnew_q) && state_q == ST_PP_OUT;
    endproperty
    a_col_change: assert property (p_col_change) else $error("column not moved");
endmodule // npp_top
`default_nettype wire

// [npp_top_tb.sv]
// testbench: host model drives the link, byte reference of page and mode
// assumes npp_top and npp_host_model compiled before
`timescale 1ns/10ps
`default_nettype none
module npp_top_tb;
    import npp_pkg::*;
    localparam int PLC = 64;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic resetn = 1'b0;
    logic sync_mode = 1'b0;
    logic luns_idle = 1'b0;
    npp_link_in_type link_in;
    npp_link_out_type link_out;
    logic rb_n;
    logic array_mode;
    int fail_count = 0;
    int cmp_count = 0;
    int col = 0;
    int low_cnt = 0;
    logic [7:0] q, s0, s1;
    logic [7:0] head [0:15] = '{8'h4f, 8'h4e, 8'h46, 8'h49, 8'h1e, 8'h00, 8'hd8, 8'h01,
        8'hff, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};

    initial forever #20 ref_clk = ~ref_clk;
    initial
    begin
        #13;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge ref_clk) if (!rb_n) low_cnt++;

    npp_top #(.PAGE_LOAD_CYC(PLC)) i_dut (.ref_clk_i(ref_clk), .resetn_i(resetn),
        .link_clk_i(link_clk), .link_i(link_in), .sync_mode_i(sync_mode),
        .luns_idle_i(luns_idle), .link_o(link_out), .rb_n_o(rb_n), .array_mode_o(array_mode));
    npp_host_model i_host (.link_clk_i(link_clk), .dev_i(link_out), .link_o(link_in));

    function automatic logic [7:0] exp_byte(int c);
        return (c % 256 < 16) ? head[c % 256] : 8'h00;
    endfunction
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        cmp_count++;
        if (e !== s)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic rd_page(int n);
        logic d;
        repeat (n)
        begin
            d = link_out.dqs;
            i_host.rd(q);
            chk("page byte", exp_byte(col), q);
            chk("dqs", {7'h00, d ^ sync_mode}, {7'h00, link_out.dqs});
            chk("data enable", 8'h01, {7'h00, link_out.dq_oe});
            col = (col + 1) % (PP_BYTES * PP_COPIES);
        end
    endtask
    task automatic col_to(int c);
        i_host.cmd(CMD_COL);
        i_host.adr(c[7:0]);
        i_host.adr({5'h00, c[10:8]});
        i_host.cmd(CMD_COL_CFM);
        col = c;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #1000000;
        fail_count++;
        final_report;
    end

    initial
    begin
        void'($urandom(70216));
        repeat (3) @(negedge link_clk);
        resetn = 1'b1;
        chk("reset pins", 8'h01, {5'h00, array_mode, link_out.dq_oe, rb_n});
        for (int i = 0; i < 2; i++)
        begin
            s0 = 8'($urandom);
            s0[0] = i[0];
            i_host.cmd(CMD_SET_FEAT);
            i_host.adr(FEAT_ADDR_ARRAY);
            i_host.wr(s0);
            repeat (3) i_host.wr(8'h00);
            i_host.cmd(CMD_GET_FEAT);
            i_host.adr(FEAT_ADDR_ARRAY);
            for (int j = 0; j < 4; j++)
            begin
                i_host.rd(q);
                chk("feature byte", (j == 0) ? {7'h00, s0[0]} : 8'h00, q);
            end
            chk("array mode", {7'h00, s0[0]}, {7'h00, array_mode});
        end
        $display("features test done");
        i_host.cmd(CMD_READ_PP);
        i_host.adr(PP_ADDR_VAL);
        repeat (4) @(negedge link_clk);
        chk("busy count", 8'h00, low_cnt[7:0]);
        $display("refusal test done");
        @(negedge ref_clk);
        luns_idle = 1'b1;
        repeat (3) @(negedge link_clk);
        i_host.page_open(s0, s1);
        chk("status busy", 8'h00, s0);
        chk("status ready", 8'h60, s1);
        chk("load length", 8'(PLC), low_cnt[7:0]);
        rd_page(12);
        $display("page test done");
        col_to(256 * int'($urandom % 6) + 252);
        rd_page(8);
        col_to(1788);
        rd_page(8);
        $display("column test done");
        @(negedge ref_clk);
        sync_mode = 1'b1;
        repeat (3) @(negedge link_clk);
        rd_page(6);
        $display("sync test done");
        i_host.cmd(CMD_RESET);
        repeat (2) @(negedge link_clk);
        chk("mode after reset", 8'h00, {7'h00, array_mode});
        chk("output after reset", 8'h00, {7'h00, link_out.dq_oe});
        $display("reset test done");
        final_report;
    end
endmodule // npp_top_tb
`default_nettype wire
